// [kss_cmd_dec.sv]
`timescale 1ns/100ps
// ********************************************************************
// Command byte classifier
// ********************************************************************
module kss_cmd_dec (
  // Received byte
  input wire logic [7:0] byte_in,
  // Command class
  output kss_pkg::kss_cmd_t cmd_out
);
  import kss_pkg::*;

  // Codes do not overlap; unknown bytes give no command
  always_comb begin
    cmd_out = KSS_CMD_NONE;
    if (byte_in == KSS_CODE_ADV) begin
      cmd_out = KSS_CMD_ADV;
    end else if (byte_in[7:5] == KSS_OP_PRESC) begin
      if (byte_in[4:1] <= KSS_PRESC_MAX) begin
        cmd_out = KSS_CMD_PRESC;
      end
    end else if (byte_in[7:1] == KSS_OP_CHAN) begin
      cmd_out = KSS_CMD_CHAN;
    end else if (byte_in[7:6] == KSS_OP_BPF) begin
      cmd_out = KSS_CMD_BPF;
    end else if (byte_in[7:6] == KSS_OP_GAIN) begin
      cmd_out = KSS_CMD_GAIN;
    end else if (byte_in[7:5] == KSS_OP_TC) begin
      cmd_out = KSS_CMD_TC;
    end
  end

endmodule // kss_cmd_dec

// [kss_decoder.sv]
`timescale 1ns/100ps
// ********************************************************************
// Function
// - Code 010xxxxx loads prescaler from bits 4..1, codes 0000 to 1000
// - Prescaler bit 0 low drives serial output, high makes it float
// - Code 1110000x selects channel from bit 0
// - Code 00xxxxxx stores six-bit band-pass index
// - Code 10xxxxxx stores six-bit gain index
// - Code 110xxxxx stores five-bit integrator time constant index
// - Exact byte 0x71 switches to advanced mode
// - Advanced mode persists until power-up reset only
// - Command and response bytes travel most significant bit first
// - Advanced mode returns the response of the previous command
// - Device holds a ten-bit integrator result readable in advanced mode
// - Prescaler command answers integrator bits 7..0
// - Channel command answers integrator bits 9..8 then six zeros
// - Band-pass and gain commands answer fixed pattern bytes
// - Time constant answers 0x71, advanced entry answers 0x8E
// - After power-up serial output echoes serial input
// ********************************************************************
module kss_decoder (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Serial link pins
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // Integrator result from the signal chain
  input wire logic [9:0] integ_result_in,
  // Settings and mode
  output kss_pkg::kss_cfg_t cfg_out,
  output logic adv_mode_out
);
  import kss_pkg::*;

  // ******************************************************************
  // Pin sampling and edges
  // ******************************************************************
  kss_spi_t pins_raw;
  kss_spi_t pins_s;
  logic sclk_prev_q, sclk_prev_d;
  logic cs_prev_q, cs_prev_d;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;

  assign pins_raw = '{sclk: spi_sclk_in, cs_n: spi_cs_n_in,
    sdi: spi_sdi_in};

  kss_sync #(.W(3), .RST(KSS_SPI_IDLE)) u_sync (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .d_in(pins_raw),
    .q_out(pins_s)
  );

  // Previous levels for edge detection
  always_comb begin
    sclk_prev_d = pins_s.sclk;
    cs_prev_d = pins_s.cs_n;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_prev_q <= KSS_SPI_IDLE.sclk;
      cs_prev_q <= KSS_SPI_IDLE.cs_n;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      cs_prev_q <= cs_prev_d;
    end
  end

  // Edge strobes
  assign sclk_rise = pins_s.sclk & ~sclk_prev_q;
  assign sclk_fall = ~pins_s.sclk & sclk_prev_q;
  assign cs_fall = ~pins_s.cs_n & cs_prev_q;
  assign cs_rise = pins_s.cs_n & ~cs_prev_q;

  // ******************************************************************
  // Frame shifting
  // ******************************************************************
  kss_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] resp_q, resp_d;
  logic commit;
  kss_cmd_t cmd;

  // Frame tracker; sample on rising, shift out on falling clock
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    unique case (st_q)
      KSS_ST_IDLE: begin
        if (cs_fall) begin
          st_d = KSS_ST_SHIFT;
          cnt_d = KSS_BIT_FIRST;
          tx_d = resp_q;
        end
      end
      KSS_ST_SHIFT: begin
        if (cs_rise) begin
          st_d = KSS_ST_IDLE;
        end else begin
          if (sclk_rise) begin
            rx_d = {rx_q[6:0], pins_s.sdi};
            cnt_d = 3'(cnt_q + KSS_BIT_STEP);
            if (cnt_q == KSS_BIT_LAST) begin
              st_d = KSS_ST_FULL;
            end
          end
          if (sclk_fall) begin
            tx_d = {tx_q[6:0], 1'b0};
          end
        end
      end
      KSS_ST_FULL: begin
        if (cs_rise) begin
          st_d = KSS_ST_IDLE;
        end else if (sclk_rise) begin
          st_d = KSS_ST_OVER;
        end else if (sclk_fall) begin
          tx_d = {tx_q[6:0], 1'b0};
        end
      end
      KSS_ST_OVER: begin
        if (cs_rise) begin
          st_d = KSS_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= KSS_ST_IDLE;
      cnt_q <= KSS_BIT_FIRST;
      rx_q <= KSS_RESP_NONE;
      tx_q <= KSS_RESP_NONE;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
    end
  end

  // ******************************************************************
  // Decode and settings
  // ******************************************************************
  kss_cfg_t cfg_q, cfg_d;
  logic adv_q, adv_d;
  logic [9:0] integ_q;

  kss_cmd_dec u_dec (
    .byte_in(rx_q),
    .cmd_out(cmd)
  );

  // A full byte commits only when select is released
  assign commit = cs_rise & (st_q == KSS_ST_FULL);

  // Setting updates and the response for the next frame
  always_comb begin
    cfg_d = cfg_q;
    adv_d = adv_q;
    resp_d = resp_q;
    if (commit) begin
      unique case (cmd)
        KSS_CMD_PRESC: begin
          cfg_d.presc = rx_q[4:1];
          cfg_d.sdo_hiz = rx_q[0];
          resp_d = integ_q[7:0];
        end
        KSS_CMD_CHAN: begin
          cfg_d.chan = rx_q[0];
          resp_d = {integ_q[9:8], KSS_RESP_PAD};
        end
        KSS_CMD_BPF: begin
          cfg_d.bpf = rx_q[5:0];
          resp_d = KSS_PAT_HI;
        end
        KSS_CMD_GAIN: begin
          cfg_d.gain = rx_q[5:0];
          resp_d = KSS_PAT_LO;
        end
        KSS_CMD_TC: begin
          cfg_d.tc = rx_q[4:0];
          resp_d = KSS_RESP_CFG;
        end
        KSS_CMD_ADV: begin
          adv_d = 1'b1;
          resp_d = KSS_RESP_CFG_INV;
        end
        KSS_CMD_NONE: begin
          resp_d = KSS_RESP_NONE;
        end
      endcase
    end
  end

  // Advanced mode clears only on reset
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_q <= KSS_CFG_RST;
      adv_q <= 1'b0;
      resp_q <= KSS_RESP_NONE;
      integ_q <= KSS_INTEG_RST;
    end else begin
      cfg_q <= cfg_d;
      adv_q <= adv_d;
      resp_q <= resp_d;
      integ_q <= integ_result_in;
    end
  end

  // ******************************************************************
  // Serial output
  // ******************************************************************
  logic sdo_q, sdo_d;
  logic sdo_oe_q, sdo_oe_d;

  // Echo in default mode, response bit in advanced mode
  always_comb begin
    sdo_d = adv_q ? tx_q[7] : pins_s.sdi;
    sdo_oe_d = ~pins_s.cs_n & ~cfg_q.sdo_hiz;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
    end
  end

  assign sdo_out = sdo_q;
  assign sdo_oe_out = sdo_oe_q;
  assign cfg_out = cfg_q;
  assign adv_mode_out = adv_q;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_presc;
    commit && cmd == KSS_CMD_PRESC |=> cfg_q.presc == $past(rx_q[4:1]);
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler");
  property p_hiz;
    cfg_q.sdo_hiz && $past(cfg_q.sdo_hiz) |-> !sdo_oe_q;
  endproperty
  a_hiz: assert property (p_hiz) else $error("sdo not floating");
  property p_chan;
    commit && cmd == KSS_CMD_CHAN |=> cfg_q.chan == $past(rx_q[0]);
  endproperty
  a_chan: assert property (p_chan) else $error("channel");
  property p_bpf;
    commit && cmd == KSS_CMD_BPF |=> cfg_q.bpf == $past(rx_q[5:0]);
  endproperty
  a_bpf: assert property (p_bpf) else $error("band-pass index");
  property p_gain;
    commit && cmd == KSS_CMD_GAIN |=> cfg_q.gain == $past(rx_q[5:0]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain index");
  property p_tc;
    commit && cmd == KSS_CMD_TC |=> cfg_q.tc == $past(rx_q[4:0]);
  endproperty
  a_tc: assert property (p_tc) else $error("time constant");
  property p_adv_entry;
    commit && rx_q == KSS_CODE_ADV |=> adv_q;
  endproperty
  a_adv_entry: assert property (p_adv_entry) else $error("no entry");
  property p_adv_sticky;
    adv_q |=> adv_q [*2];
  endproperty
  a_adv_sticky: assert property (p_adv_sticky) else $error("left adv");
  property p_msb;
    st_q == KSS_ST_SHIFT && sclk_fall && !cs_rise
      |=> tx_q == {$past(tx_q[6:0]), 1'b0};
  endproperty
  a_msb: assert property (p_msb) else $error("shift order");
  property p_prev_resp;
    st_q == KSS_ST_IDLE && cs_fall |=> tx_q == $past(resp_q);
  endproperty
  a_prev_resp: assert property (p_prev_resp) else $error("resp");
  property p_resp_lo;
    commit && cmd == KSS_CMD_PRESC |=> resp_q == $past(integ_q[7:0]);
  endproperty
  a_resp_lo: assert property (p_resp_lo) else $error("low byte");
  property p_resp_hi;
    commit && cmd == KSS_CMD_CHAN
      |=> resp_q == {$past(integ_q[9:8]), KSS_RESP_PAD};
  endproperty
  a_resp_hi: assert property (p_resp_hi) else $error("high bits");
  property p_pattern;
    commit && cmd inside {KSS_CMD_BPF, KSS_CMD_GAIN}
      |=> resp_q == ($past(cmd) == KSS_CMD_BPF ? KSS_PAT_HI : KSS_PAT_LO);
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern");
  property p_cfg_byte;
    commit && cmd == KSS_CMD_TC |=> resp_q == KSS_RESP_CFG;
  endproperty
  a_cfg_byte: assert property (p_cfg_byte) else $error("cfg byte");
  property p_echo;
    !adv_q |=> sdo_q == $past(pins_s.sdi);
  endproperty
  a_echo: assert property (p_echo) else $error("echo");
  property p_frame;
    cs_rise && st_q != KSS_ST_FULL
      |=> cfg_q == $past(cfg_q) && adv_q == $past(adv_q);
  endproperty
  a_frame: assert property (p_frame) else $error("short frame");
  property p_unknown;
    commit && cmd == KSS_CMD_NONE
      |=> cfg_q == $past(cfg_q) && adv_q == $past(adv_q);
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown");

  c_adv_entry: cover property (commit && cmd == KSS_CMD_ADV);
  c_adv_read: cover property (adv_q && commit && cmd == KSS_CMD_PRESC);
  c_over: cover property (st_q == KSS_ST_OVER && cs_rise);
  c_hiz: cover property (cfg_q.sdo_hiz && !pins_s.cs_n);

endmodule // kss_decoder

// [kss_decoder_tb_top.sv]
`timescale 1ns/100ps
// ****************************************************************
// Self-checking bench of the command decoder
// ****************************************************************
module kss_decoder_tb_top;
  import kss_pkg::*;
  logic core_clk_in;
  logic nrst_in;
  kss_spi_t spi;
  logic sdo;
  logic sdo_oe;
  logic [9:0] integ;
  kss_cfg_t cfg;
  logic adv;
  kss_cfg_t exp_cfg;
  logic [7:0] rx;
  logic oe_any;
  int error_cnt;
  int num_checks;

  // Device and host
  kss_decoder i_dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .spi_sclk_in(spi.sclk), .spi_cs_n_in(spi.cs_n), .spi_sdi_in(spi.sdi),
    .sdo_out(sdo), .sdo_oe_out(sdo_oe), .integ_result_in(integ),
    .cfg_out(cfg), .adv_mode_out(adv));
  kss_host_model i_host (.spi_out(spi), .sdo_in(sdo), .sdo_oe_in(sdo_oe));

  // Expected settings after a committed byte
  function automatic kss_cfg_t ref_apply(kss_cfg_t c, logic [7:0] b);
    kss_cfg_t n;
    n = c;
    casez (b)
      8'b010?????: begin
        if (b[4:1] <= 4'h8) begin
          n.presc = b[4:1];
          n.sdo_hiz = b[0];
        end
      end
      8'b1110000?: n.chan = b[0];
      8'b00??????: n.bpf = b[5:0];
      8'b10??????: n.gain = b[5:0];
      8'b110?????: n.tc = b[4:0];
      default: n = c;
    endcase
    return n;
  endfunction

  // Expected advanced-mode answer to a byte
  function automatic logic [7:0] ref_resp(logic [7:0] b, logic [9:0] v);
    casez (b)
      8'b010?????: return (b[4:1] <= 4'h8) ? v[7:0] : 8'h00;
      8'b1110000?: return {v[9:8], 6'h00};
      8'b00??????: return KSS_PAT_HI;
      8'b10??????: return KSS_PAT_LO;
      8'b110?????: return 8'h71;
      8'b01110001: return 8'h8E;
      default: return 8'h00;
    endcase
  endfunction

  // Compare and count
  task automatic chk(input logic [22:0] got, input logic [22:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One frame through the host, tracking expected settings
  task automatic send(input logic [7:0] tx, input int nbits);
    i_host.xfer(tx, nbits, rx, oe_any);
    if (nbits == 8) begin
      exp_cfg = ref_apply(exp_cfg, tx);
    end
  endtask

  task automatic pulse_reset();
    @(posedge core_clk_in);
    #10 nrst_in = 1'b0;
    repeat (3) @(posedge core_clk_in);
    #10 nrst_in = 1'b1;
    exp_cfg = 23'h000000;
  endtask

  task automatic t_reset_vals();
    chk(cfg, 23'h000000);
    chk(adv, 1'b0);
    chk(sdo_oe, 1'b0);
    $display("test reset_vals done");
  endtask

  task automatic t_default_cmds();
    logic [7:0] c [6] = '{8'h50, 8'hE1, 8'h27, 8'h94, 8'hC3, 8'h45};
    foreach (c[i]) begin
      send(c[i], 8);
      chk(rx, c[i]);
      chk(cfg, exp_cfg);
    end
    $display("test default_cmds done");
  endtask

  task automatic t_hiz();
    send(8'h94, 8);
    chk(oe_any, 1'b0);
    chk(cfg, exp_cfg);
    send(8'h40, 8);
    chk(cfg, exp_cfg);
    send(8'h50, 8);
    chk(oe_any, 1'b1);
    chk(rx, 8'h50);
    $display("test hiz done");
  endtask

  task automatic t_refuse();
    logic [7:0] c [4] = '{8'h7F, 8'h52, 8'hE2, 8'hF0};
    foreach (c[i]) begin
      send(c[i], 8);
      chk(cfg, exp_cfg);
      chk(adv, 1'b0);
    end
    send(8'h8F, 7);
    chk(cfg, exp_cfg);
    send(8'h71, 7);
    chk(adv, 1'b0);
    send(8'hBF, 9);
    chk(cfg, exp_cfg);
    $display("test refuse done");
  endtask

  task automatic t_adv();
    logic [7:0] c [9] = '{8'h50, 8'hE0, 8'h27, 8'h94, 8'hC3, 8'h7F,
      8'h71, 8'h00, 8'h52};
    logic [7:0] prev;
    @(posedge core_clk_in);
    #10 integ = 10'h2A5;
    send(8'h71, 8);
    chk(adv, 1'b1);
    prev = 8'h71;
    foreach (c[i]) begin
      send(c[i], 8);
      chk(rx, ref_resp(prev, integ));
      chk(cfg, exp_cfg);
      chk(adv, 1'b1);
      prev = c[i];
    end
    $display("test adv done");
  endtask

  task automatic t_power();
    pulse_reset();
    chk(adv, 1'b0);
    chk(cfg, 23'h000000);
    send(8'hA5, 8);
    chk(rx, 8'hA5);
    chk(cfg, exp_cfg);
    $display("test power done");
  endtask

  task automatic complete_run();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Core clock
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  // Main sequence
  initial begin
    nrst_in = 1'b0;
    integ = 10'h000;
    exp_cfg = 23'h000000;
    error_cnt = 0;
    num_checks = 0;
    repeat (3) @(posedge core_clk_in);
    #10 nrst_in = 1'b1;
    @(posedge core_clk_in);
    #10;
    t_reset_vals();
    t_default_cmds();
    t_hiz();
    t_refuse();
    t_adv();
    t_power();
    complete_run();
  end

  // Watchdog against a hung link
  initial begin
    #2000000;
    error_cnt++;
    $display("watchdog expired");
    complete_run();
  end
endmodule // kss_decoder_tb_top

// [kss_host_model.sv]
`timescale 1ns/100ps
// ****************************************************************
// Host side of the serial link, acting as bus master
// ****************************************************************
module kss_host_model (
  // Pins towards the device
  output kss_pkg::kss_spi_t spi_out,
  // Serial output of the device
  input wire logic sdo_in,
  input wire logic sdo_oe_in
);
  import kss_pkg::*;
  logic sdo_last;
  logic sdo_wire;

  // A released output shows the inverse of its last driven level
  always @(sdo_in or sdo_oe_in) begin
    if (sdo_oe_in) begin
      sdo_last = sdo_in;
    end
  end
  assign sdo_wire = sdo_oe_in ? sdo_in : ~sdo_last;

  // Idle pins at time zero
  initial begin
    sdo_last = 1'b0;
    spi_out = KSS_SPI_IDLE;
  end

  // One frame, MSB first; each bit is read just before the clock falls
  task automatic xfer(input logic [7:0] tx, input int nbits,
      output logic [7:0] rx, output logic oe_any);
    int i;
    rx = 8'h00;
    oe_any = 1'b0;
    spi_out.cs_n = 1'b0;
    spi_out.sdi = tx[7];
    for (i = 0; i < nbits; i++) begin
      #400;
      spi_out.sclk = 1'b1;
      #400;
      rx = {rx[6:0], sdo_wire};
      oe_any = oe_any | sdo_oe_in;
      spi_out.sclk = 1'b0;
      if (i < 7) begin
        spi_out.sdi = tx[6-i];
      end
    end
    #400;
    spi_out.cs_n = 1'b1;
    spi_out.sdi = ~spi_out.sdi;
    // Gap covers the commit delay before the next frame
    #1000;
  endtask
endmodule // kss_host_model

// [kss_pkg.sv]
// ********************************************************************
// Shared constants and types of the knock sensor command decoder
// ********************************************************************
package kss_pkg;

  // ******************************************************************
  // Command codes
  // ******************************************************************
  localparam logic [7:0] KSS_CODE_ADV = 8'h71;
  localparam logic [2:0] KSS_OP_PRESC = 3'h2;
  localparam logic [6:0] KSS_OP_CHAN = 7'h70;
  localparam logic [1:0] KSS_OP_BPF = 2'h0;
  localparam logic [1:0] KSS_OP_GAIN = 2'h2;
  localparam logic [2:0] KSS_OP_TC = 3'h6;
  localparam logic [3:0] KSS_PRESC_MAX = 4'h8;

  // ******************************************************************
  // Response bytes
  // ******************************************************************
  localparam logic [7:0] KSS_RESP_CFG = 8'h71;
  localparam logic [7:0] KSS_RESP_CFG_INV = 8'h8E;
  localparam logic [7:0] KSS_RESP_NONE = 8'h00;
  localparam logic [5:0] KSS_RESP_PAD = 6'h00;
  // Fixed pattern bytes: values are arbitrary
  localparam logic [7:0] KSS_PAT_HI = 8'h3C;
  localparam logic [7:0] KSS_PAT_LO = 8'hC3;

  // ******************************************************************
  // Counts and reset values
  // ******************************************************************
  localparam logic [2:0] KSS_BIT_FIRST = 3'h0;
  localparam logic [2:0] KSS_BIT_LAST = 3'h7;
  localparam logic [2:0] KSS_BIT_STEP = 3'h1;
  localparam logic [9:0] KSS_INTEG_RST = 10'h000;

  // Configuration held by the decoder
  typedef struct packed {
    logic [3:0] presc;
    logic sdo_hiz;
    logic chan;
    logic [5:0] bpf;
    logic [5:0] gain;
    logic [4:0] tc;
  } kss_cfg_t;

  localparam kss_cfg_t KSS_CFG_RST = '{presc: 4'h0, sdo_hiz: 1'b0,
    chan: 1'b0, bpf: 6'h00, gain: 6'h00, tc: 5'h00};

  // Serial pins as one group
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } kss_spi_t;

  localparam kss_spi_t KSS_SPI_IDLE = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};

  // Decoded command classes
  typedef enum logic [2:0] {
    KSS_CMD_NONE = 3'h0,
    KSS_CMD_PRESC = 3'h1,
    KSS_CMD_CHAN = 3'h2,
    KSS_CMD_BPF = 3'h3,
    KSS_CMD_GAIN = 3'h4,
    KSS_CMD_TC = 3'h5,
    KSS_CMD_ADV = 3'h6
  } kss_cmd_t;

  // Frame states, Gray coded along idle-shift-full-over
  typedef enum logic [1:0] {
    KSS_ST_IDLE = 2'b00,
    KSS_ST_SHIFT = 2'b01,
    KSS_ST_FULL = 2'b11,
    KSS_ST_OVER = 2'b10
  } kss_state_t;

endpackage

// [kss_sync.sv]
`timescale 1ns/100ps
// ********************************************************************
// Two-stage synchroniser for a group of pin inputs
// ********************************************************************
module kss_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Pins and synchronised copy
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule // kss_sync
